// ---- bench/fsps_flash_model.sv ----
// far-side model: data ram read port and flash array with write bookkeeping
`timescale 1ns/100ps
`default_nettype none
module fsps_flash_model
  import fsps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the sequencer
  input wire fsps_ram_req_t ram_req,
  input wire fsps_flash_req_t flash_req,
  // answers and bookkeeping
  output logic [15:0] ram_rdata,
  output logic flash_busy,
  output logic [15:0] n_wr,
  output logic [23:0] w_addr,
  output logic [23:0] w_data
);
  logic [1:0] busy_cnt;
  // ram returns its own address; stale data is inverted so it never matches by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_rdata <= 16'h0000;
      busy_cnt <= 2'h0;
      n_wr <= 16'h0000;
      w_addr <= 24'h000000;
      w_data <= 24'h000000;
    end else begin
      ram_rdata <= ram_req.req ? ram_req.addr : ~ram_rdata;
      if (flash_req.req) begin
        busy_cnt <= 2'h3;
        n_wr <= n_wr + 16'h0001;
        w_addr <= flash_req.addr;
        w_data <= flash_req.erase ? 24'hFFFFFF : flash_req.data; // erased cells read ones
      end else if (busy_cnt != 2'h0) begin
        busy_cnt <= busy_cnt - 2'h1;
      end
    end
  end
  // busy rises the cycle after a request and holds for three cycles
  assign flash_busy = busy_cnt != 2'h0;
endmodule
`default_nettype wire

// ---- bench/fsps_top_monitor.sv ----
// checker: timing relations at the sequencer's ports
`timescale 1ns/100ps
`default_nettype none
module fsps_top_monitor
  import fsps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // far side and cpu
  input wire fsps_ram_req_t ram_req,
  input wire logic [15:0] ram_rdata,
  input wire fsps_flash_req_t flash_req,
  input wire logic flash_busy,
  input wire logic cpu_stall,
  input wire logic op_done
);
  logic go_wr;
  // a go write taken on the bus, the only legal cause of a stall
  assign go_wr = psel && penable && pwrite && paddr[7:0] == FSPS_OFF_CTRL && pwdata[FSPS_BIT_GO];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access phase");
  a_done_ends_stall: assert property (op_done |-> !cpu_stall && $past(cpu_stall))
    else $error("completion pulse not tied to end of stall");
  a_done_single: assert property (op_done |=> !op_done)
    else $error("completion pulse longer than one cycle");
  a_flash_in_stall: assert property (flash_req.req |-> cpu_stall)
    else $error("flash request while cpu runs");
  a_ram_in_stall: assert property (ram_req.req |-> cpu_stall)
    else $error("ram fetch outside an operation");
  a_erase_aligned: assert property (flash_req.req && flash_req.erase |->
    flash_req.addr % 24'd1536 == 24'd0)
    else $error("erase not on page boundary");
  a_word_even: assert property (flash_req.req && !flash_req.erase |-> !flash_req.addr[0])
    else $error("word write at odd address");
  a_stall_needs_go: assert property ($rose(cpu_stall) |-> $past(go_wr))
    else $error("stall without a go write");
  a_req_pulse: assert property (flash_req.req |=> !flash_req.req)
    else $error("flash request longer than one cycle");
endmodule
bind fsps_top fsps_top_monitor u_fsps_top_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .ram_req, .ram_rdata, .flash_req, .flash_busy,
  .cpu_stall, .op_done);
`default_nettype wire

// ---- bench/test_fsps_top.sv ----
// testbench: register-driven scenarios for the flash self-programming sequencer
`timescale 1ns/100ps
`default_nettype none
module test_fsps_top;
  import fsps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_busy, cpu_stall, op_done;
  logic se;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] ram_rdata, nw;
  logic [23:0] w_addr, w_data;
  fsps_ram_req_t ram_req;
  fsps_flash_req_t flash_req;
  int n_fail, n_checks;
  fsps_top u_fsps_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ram_req, .ram_rdata, .flash_req, .flash_busy, .cpu_stall, .op_done);
  fsps_flash_model u_fsps_flash_model (.pclk, .presetn, .ram_req, .flash_req, .ram_rdata,
    .flash_busy, .n_wr(nw), .w_addr, .w_data);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; idles a cycle after so psel is never driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic keys();
    apb(1'b1, FSPS_OFF_KEY, {24'h000000, FSPS_KEY1});
    apb(1'b1, FSPS_OFF_KEY, {24'h000000, FSPS_KEY2});
  endtask
  task automatic t_regs();
    logic [7:0] offs [4] = '{FSPS_OFF_CTRL, FSPS_OFF_SRC, FSPS_OFF_TGT, FSPS_OFF_STAT};
    foreach (offs[k]) begin
      apb(1'b0, offs[k], 32'h00000000);
      chk(rd, 32'h00000000);
    end
    apb(1'b0, 8'h1C, 32'h00000000);
    chk({31'h0, se}, 32'h00000001);
    chk(rd, 32'h00000000);
  endtask
  // no key, key spoilt by another write, misaligned target: all refused, flash untouched
  task automatic t_refuse();
    logic [15:0] n0;
    for (int k = 0; k < 3; k++) begin
      n0 = nw;
      apb(1'b1, FSPS_OFF_TGT, (k == 2) ? 32'h00000602 : 32'h00000604);
      if (k > 0) keys();
      if (k == 1) apb(1'b1, FSPS_OFF_SRC, 32'h00000100);
      apb(1'b1, FSPS_OFF_CTRL, 32'h0000C001);
      repeat (40) @(posedge pclk);
      apb(1'b0, FSPS_OFF_CTRL, 32'h00000000);
      chk(rd & 32'h0000A000, 32'h00002000);
      chk({16'h0, nw}, {16'h0, n0});
    end
  endtask
  task automatic op(input logic [31:0] c, input logic [23:0] t, input logic [15:0] n,
                    input logic [23:0] la, input logic [23:0] ld);
    int i = 0;
    logic [15:0] n0;
    apb(1'b1, FSPS_OFF_TGT, {8'h00, t});
    n0 = nw;
    keys();
    apb(1'b1, FSPS_OFF_CTRL, c);
    chk({31'h0, cpu_stall}, 32'h00000001);
    while (op_done !== 1'b1 && i < 3000) begin
      @(posedge pclk);
      i++;
    end
    chk({31'h0, i < 3000}, 32'h00000001);
    @(posedge pclk);
    chk({31'h0, cpu_stall}, 32'h00000000);
    apb(1'b0, FSPS_OFF_CTRL, 32'h00000000);
    chk(rd & 32'h0000B000, 32'h00001000);
    chk({16'h0, nw - n0}, {16'h0, n});
    chk({8'h00, w_addr}, {8'h00, la});
    chk({8'h00, w_data}, {8'h00, ld});
  endtask
  // erase the page first, then program inside it
  task automatic t_program();
    op(32'h0000C003, 24'h000600, 16'd1, 24'h000600, 24'hFFFFFF);
    apb(1'b1, FSPS_OFF_LAT_LO, 32'h00123456);
    apb(1'b1, FSPS_OFF_LAT_HI, 32'h00ABCDEF);
    op(32'h0000C001, 24'h000604, 16'd2, 24'h000606, 24'hABCDEF);
    apb(1'b1, FSPS_OFF_SRC, 32'h00000100);
    op(32'h0000C002, 24'h0006C0, 16'd64, 24'h00073E, 24'hFE01FC);
    apb(1'b1, FSPS_OFF_SRC, 32'h00000100);
    op(32'h0000C202, 24'h0006C0, 16'd64, 24'h00073E, 24'h0101BE);
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_refuse();
    t_program();
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- design/fsps_apb_slave.sv ----
// apb slave front end: decodes address and issues one-cycle write/read strobes
`timescale 1ns/100ps
`default_nettype none
module fsps_apb_slave
  import fsps_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  output logic pready,
  output logic pslverr,
  // core side
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] reg_off,
  input wire logic decode_ok
);
  typedef struct packed {
    logic ready;
    logic err;
  } fsps_apb_st_t;
  fsps_apb_st_t st, next_st;

  // access accepted in access phase; ready one cycle later so read data settles
  always_comb begin
    next_st.ready = psel && penable && !st.ready;
    next_st.err = psel && penable && !st.ready && !decode_ok;
  end
  assign wr_stb = psel && penable && !st.ready && pwrite && decode_ok;
  assign rd_stb = psel && penable && !st.ready && !pwrite;
  assign reg_off = paddr[7:0];
  assign pready = st.ready;
  assign pslverr = st.err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- design/fsps_pkg.sv ----
// package: constants, types and register map of the flash self-programming sequencer
// Function
// RULE1: flash rows hold 64 instruction words, 192 bytes; one row per row write.
// RULE2: erase works one page at a time, a page is 8 rows or 512 words.
// RULE3: pages align on 1536-byte, rows on 192-byte boundaries from memory start.
// RULE4: software puts row data in RAM and its start address in source pointer.
// RULE5: row write fills latches from RAM itself, advancing source and target pointers.
// RULE6: control bit 9 selects compressed or uncompressed RAM row format.
// RULE7: compressed format takes second instruction's top byte from second word's upper byte.
// RULE8: software loads two 24-bit latch words; device programs the latched pair.
// RULE9: double-instruction programming only at target addresses that are multiples of four.
// RULE10: software erases the containing page before programming a location.
// RULE11: unlock key sequence must precede any erase or program, else refused.
// RULE12: setting go bit 15 starts the operation; device clears it when done.
// RULE13: the processor stalls while a self-programming operation runs.
// RULE14: a completion event may be raised after each erase or program.
// RULE15: software should place two no-ops after starting a programming sequence.
// RULE16: go without immediately preceding unlock is ignored; flash left unchanged.
package fsps_pkg;
  localparam logic [7:0] FSPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] FSPS_OFF_KEY = 8'h04;
  localparam logic [7:0] FSPS_OFF_SRC = 8'h08;
  localparam logic [7:0] FSPS_OFF_TGT = 8'h0C;
  localparam logic [7:0] FSPS_OFF_LAT_LO = 8'h10;
  localparam logic [7:0] FSPS_OFF_LAT_HI = 8'h14;
  localparam logic [7:0] FSPS_OFF_STAT = 8'h18;
  localparam int FSPS_BIT_GO = 15;
  localparam int FSPS_BIT_WREN = 14;
  localparam int FSPS_BIT_ERR = 13;
  localparam int FSPS_BIT_DONE = 12;
  localparam int FSPS_BIT_FMT = 9;
  localparam logic [1:0] FSPS_OP_DOUBLE = 2'h1;
  localparam logic [1:0] FSPS_OP_ROW = 2'h2;
  localparam logic [1:0] FSPS_OP_PAGE = 2'h3;
  localparam logic [15:0] FSPS_CTRL_RST = 16'h0000;
  localparam logic [7:0] FSPS_KEY1 = 8'h55;
  localparam logic [7:0] FSPS_KEY2 = 8'hAA;
  localparam logic [6:0] FSPS_ROW_WORDS = 7'h40;
  localparam logic [9:0] FSPS_PAGE_WORDS = 10'h200;
  localparam logic [3:0] FSPS_PAGE_ROWS = 4'h8;
  localparam logic [23:0] FSPS_ROW_BYTES = 24'h0000C0;
  localparam logic [23:0] FSPS_PAGE_BYTES = 24'h000600;
  localparam logic [23:0] FSPS_ADDR_STEP = 24'h000002;
  localparam logic [15:0] FSPS_RAM_STEP = 16'h0002;
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b000,
    FSPS_RD_A = 3'b001,
    FSPS_RD_B = 3'b011,
    FSPS_RD_C = 3'b010,
    FSPS_WR = 3'b110,
    FSPS_WAIT = 3'b111,
    FSPS_DONE = 3'b101
  } fsps_state_t;
  typedef struct packed {
    logic req;
    logic erase;
    logic [23:0] addr;
    logic [23:0] data;
  } fsps_flash_req_t;
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } fsps_ram_req_t;
endpackage

// ---- design/fsps_top.sv ----
// flash self-programming sequencer: register file, op sequencer, ram fetch and flash drive
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module fsps_top
  import fsps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data ram read port, answers one cycle after a request
  output fsps_ram_req_t ram_req,
  input wire logic [15:0] ram_rdata,
  // flash array
  output fsps_flash_req_t flash_req,
  input wire logic flash_busy,
  // cpu
  output logic cpu_stall,
  output logic op_done
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] src;
    logic [23:0] tgt;
    logic [23:0] lat_lo;
    logic [23:0] lat_hi;
    fsps_state_t fsm;
    logic [6:0] cnt;
    logic [3:0] rows;
    logic [15:0] w0;
    logic [15:0] w1;
    logic pair_hi;
    logic [7:0] keep_msb;
    logic wait_seen;
    fsps_flash_req_t fl;
    fsps_ram_req_t rr;
    logic [31:0] rdata;
    logic stall;
    logic done;
  } fsps_st_t;
  fsps_st_t st, next_st;

  logic wr_stb;
  logic rd_stb;
  logic [7:0] reg_off;
  logic decode_ok;
  logic armed;
  logic key_wr;

  // byte address is even word pairs; low bit unused by the 24-bit flash word map
  function automatic logic is_aligned(input logic [23:0] a, input logic [23:0] blk);
    is_aligned = (a % blk) == 24'h000000;
  endfunction

  assign decode_ok = (reg_off == FSPS_OFF_CTRL) || (reg_off == FSPS_OFF_KEY) ||
                     (reg_off == FSPS_OFF_SRC) || (reg_off == FSPS_OFF_TGT) ||
                     (reg_off == FSPS_OFF_LAT_LO) || (reg_off == FSPS_OFF_LAT_HI) ||
                     (reg_off == FSPS_OFF_STAT);
  assign key_wr = wr_stb && (reg_off == FSPS_OFF_KEY);

  fsps_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .reg_off(reg_off),
    .decode_ok(decode_ok)
  );

  fsps_unlock u_key (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(key_wr),
    .key_data(pwdata[7:0]),
    .other_wr(wr_stb && !key_wr),
    .armed(armed)
  );

  // sequencer and register file
  always_comb begin
    logic go_req;
    logic [1:0] op;
    logic ok;
    go_req = 1'b0;
    op = 2'h0;
    ok = 1'b0;
    next_st = st;
    next_st.done = 1'b0;
    next_st.rr.req = 1'b0;
    next_st.fl.req = 1'b0;
    // register writes; control locked while an operation runs
    if (wr_stb) begin
      case (reg_off)
        FSPS_OFF_CTRL: begin
          if (st.fsm == FSPS_IDLE) begin
            next_st.ctrl = pwdata[15:0];
            next_st.ctrl[FSPS_BIT_GO] = 1'b0;
            next_st.ctrl[FSPS_BIT_ERR] = st.ctrl[FSPS_BIT_ERR];
            next_st.ctrl[FSPS_BIT_DONE] = st.ctrl[FSPS_BIT_DONE];
            go_req = pwdata[FSPS_BIT_GO];
          end
        end
        FSPS_OFF_SRC: next_st.src = pwdata[15:0]; // RULE4
        FSPS_OFF_TGT: next_st.tgt = pwdata[23:0];
        FSPS_OFF_LAT_LO: next_st.lat_lo = pwdata[23:0]; // RULE8
        FSPS_OFF_LAT_HI: next_st.lat_hi = pwdata[23:0]; // RULE8
        default: ;
      endcase
    end
    // start: needs unlock, write enable and a legal aligned target
    op = pwdata[1:0];
    if (go_req) begin
      case (op)
        FSPS_OP_DOUBLE: ok = st.tgt[1:0] == 2'b00; // RULE9
        FSPS_OP_ROW: ok = is_aligned(st.tgt, FSPS_ROW_BYTES); // RULE3
        FSPS_OP_PAGE: ok = is_aligned(st.tgt, FSPS_PAGE_BYTES); // RULE3
        default: ok = 1'b0;
      endcase
      ok = ok && armed && pwdata[FSPS_BIT_WREN]; // RULE11
      if (ok) begin
        next_st.ctrl[FSPS_BIT_GO] = 1'b1; // RULE12
        next_st.ctrl[FSPS_BIT_DONE] = 1'b0;
        next_st.ctrl[FSPS_BIT_ERR] = 1'b0;
        next_st.stall = 1'b1; // RULE13
        next_st.cnt = '0;
        next_st.rows = '0;
        next_st.pair_hi = 1'b0;
        if (op == FSPS_OP_ROW) begin
          next_st.fsm = FSPS_RD_A; // RULE5
          next_st.rr.req = 1'b1;
          next_st.rr.addr = st.src;
          next_st.src = st.src + FSPS_RAM_STEP;
        end else begin
          next_st.fsm = FSPS_WR;
        end
      end else begin
        next_st.ctrl[FSPS_BIT_ERR] = 1'b1; // RULE16
      end
    end
    case (st.fsm)
      FSPS_IDLE: ;
      // first ram word is in flight; ask for the second one now
      FSPS_RD_A: begin
        next_st.src = st.src + FSPS_RAM_STEP; // RULE5
        next_st.rr.req = 1'b1;
        next_st.rr.addr = st.src;
        next_st.fsm = FSPS_RD_B;
      end
      // first word arrives; for the odd compressed word ram is not answering yet
      FSPS_RD_B: begin
        if (!(st.ctrl[FSPS_BIT_FMT] && st.pair_hi)) begin
          next_st.w0 = ram_rdata;
        end
        next_st.fsm = FSPS_RD_C;
      end
      // second word: upper bytes, or the low half of the odd compressed word
      FSPS_RD_C: begin
        if (st.ctrl[FSPS_BIT_FMT] && st.pair_hi) begin
          next_st.w0 = ram_rdata;
        end else begin
          next_st.w1 = ram_rdata;
        end
        next_st.fsm = FSPS_WR;
      end
      // drive one 24-bit word into the array
      FSPS_WR: begin
        next_st.fl.req = 1'b1;
        next_st.fl.addr = st.tgt;
        next_st.wait_seen = 1'b0;
        case (st.ctrl[1:0])
          FSPS_OP_PAGE: begin
            next_st.fl.erase = 1'b1; // RULE2
            next_st.fl.data = '0;
          end
          FSPS_OP_DOUBLE: begin
            next_st.fl.erase = 1'b0;
            next_st.fl.data = st.pair_hi ? st.lat_hi : st.lat_lo; // RULE8
          end
          default: begin
            next_st.fl.erase = 1'b0;
            if (st.ctrl[FSPS_BIT_FMT]) begin // RULE6
              // compressed: msb of second word lives in w1 upper byte
              next_st.fl.data = st.pair_hi ? {st.keep_msb, st.w0} // RULE7
                                           : {st.w1[7:0], st.w0};
              next_st.keep_msb = st.w1[15:8];
            end else begin
              next_st.fl.data = {st.w1[7:0], st.w0};
            end
          end
        endcase
        next_st.fsm = FSPS_WAIT;
      end
      // wait for the array to take and finish the word
      FSPS_WAIT: begin
        if (flash_busy) begin
          next_st.wait_seen = 1'b1;
        end else if (st.wait_seen) begin
          next_st.fsm = FSPS_DONE;
          if (st.ctrl[1:0] == FSPS_OP_PAGE) begin
            next_st.tgt = st.tgt + FSPS_PAGE_BYTES;
          end else begin
            next_st.tgt = st.tgt + FSPS_ADDR_STEP; // RULE5
            next_st.pair_hi = !st.pair_hi;
            next_st.cnt = st.cnt + 7'h01;
            if (st.ctrl[1:0] == FSPS_OP_DOUBLE && !st.pair_hi) begin
              next_st.fsm = FSPS_WR; // RULE8
            end else if (st.ctrl[1:0] == FSPS_OP_ROW &&
                         (st.cnt + 7'h01) != FSPS_ROW_WORDS) begin // RULE1
              next_st.rr.req = 1'b1;
              next_st.rr.addr = st.src;
              next_st.src = st.src + FSPS_RAM_STEP;
              // odd compressed word needs one more ram word, the others need two
              if (st.ctrl[FSPS_BIT_FMT] && !st.pair_hi) begin
                next_st.fsm = FSPS_RD_B;
              end else begin
                next_st.fsm = FSPS_RD_A;
              end
            end
          end
        end
      end
      // finish: clear go, release cpu, pulse completion
      FSPS_DONE: begin
        next_st.fsm = FSPS_IDLE;
        next_st.ctrl[FSPS_BIT_GO] = 1'b0; // RULE12
        next_st.ctrl[FSPS_BIT_DONE] = 1'b1;
        next_st.stall = 1'b0; // RULE13
        next_st.done = 1'b1; // RULE14
      end
      default: next_st.fsm = FSPS_IDLE;
    endcase
    // read mux, captured so prdata comes from a flop
    if (rd_stb) begin
      case (reg_off)
        FSPS_OFF_CTRL: next_st.rdata = {16'h0000, st.ctrl};
        FSPS_OFF_SRC: next_st.rdata = {16'h0000, st.src};
        FSPS_OFF_TGT: next_st.rdata = {8'h00, st.tgt};
        FSPS_OFF_LAT_LO: next_st.rdata = {8'h00, st.lat_lo};
        FSPS_OFF_LAT_HI: next_st.rdata = {8'h00, st.lat_hi};
        FSPS_OFF_STAT: next_st.rdata = {25'h0000000, st.cnt};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  assign prdata = st.rdata;
  assign ram_req = st.rr;
  assign flash_req = st.fl;
  assign cpu_stall = st.stall;
  assign op_done = st.done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= FSPS_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- design/fsps_unlock.sv ----
// unlock key tracker: two-write key sequence arms only the register write that immediately follows it
`timescale 1ns/100ps
`default_nettype none
module fsps_unlock
  import fsps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // key writes and all other register writes
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic other_wr,
  output logic armed
);
  typedef struct packed {
    logic half;
    logic armed;
  } fsps_key_st_t;
  fsps_key_st_t st, next_st;

  // any other register write breaks the sequence so the unlock must be immediate
  always_comb begin
    next_st = st;
    if (key_wr) begin
      next_st.armed = st.half && (key_data == FSPS_KEY2); // RULE11
      next_st.half = (key_data == FSPS_KEY1);
    end else if (other_wr) begin
      next_st = '0; // RULE16
    end
  end
  assign armed = st.armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire
